//--- hdl/pzl_status.sv
// Purpose: zone comparison, soft limit, coordinate and latch status flags
// Assumes: position inputs from the motion core on i_clk; host pins asynchronous
// Notes: wishbone slave answers every access one cycle after the request
`timescale 1ns/1ps
module pzl_status
  import pzl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire pzl_wb_req_s i_wb,
  input wire pzl_mot_s i_mot,
  input wire logic i_advance,
  input wire logic i_latch_clear,
  input wire logic i_pulse_inhibit,
  input wire logic i_pulse,
  input wire logic i_pulse_dir,
  output pzl_wb_rsp_s o_wb,
  output pzl_flags_s o_flags,
  output logic [31:0] o_lost_count
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [3:0] ctrl;
    logic [31:0] slf;
    logic [31:0] slr;
    logic [15:0] zcfg;
    logic [N_ZONE-1:0][31:0] zu;
    logic [N_ZONE-1:0][31:0] zl;
    logic [N_OP-1:0][31:0] oo;
    logic [N_OP-1:0][31:0] ow;
    logic [31:0] lost;
    logic [4:0] sy1;
    logic [4:0] sy2;
    logic [4:0] prev;
    pzl_flags_s flags;
  } pzl_st_s;

  pzl_st_s st_q;
  pzl_st_s st_d;

  function automatic logic near(input logic [31:0] p, input logic [31:0] c0,
                                input logic [31:0] off, input logic [31:0] w);
    logic signed [33:0] d;
    logic signed [33:0] ws;
    d = 34'($signed(p)) - 34'($signed(c0)) - 34'($signed(off));
    ws = 34'($signed(w));
    near = !w[31] && (d <= ws) && (d >= -ws);
  endfunction : near

  function automatic logic [31:0] bmask(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    bmask = r;
  endfunction : bmask

  logic [N_ZONE-1:0] zone_hit;

  genvar c;
  generate
    for (c = 0; c < N_ZONE; c++) begin : g_zone
      logic [31:0] p;
      logic signed [31:0] ps;
      logic signed [31:0] u;
      logic signed [31:0] l;
      logic abs_hit;
      assign p = st_q.zcfg[Z_SRC + c] ? i_mot.cmd_pos : i_mot.fb_pos;
      assign ps = $signed(p);
      assign u = $signed(st_q.zu[c]);
      assign l = $signed(st_q.zl[c]);
      always_comb begin
        if (u > l) begin
          abs_hit = (ps >= l) && (ps <= u);
        end else if (u < l) begin
          abs_hit = (ps <= u) || (ps >= l);
        end else begin
          abs_hit = (ps == u);
        end
      end
      // relative mode: centre at target plus upper, half-width lower
      assign zone_hit[c] = st_q.zcfg[c] ? near(p, i_mot.target, st_q.zu[c], st_q.zl[c])
                                        : abs_hit;
    end
  endgenerate

  logic wb_req;
  logic adv_edge;
  logic clr_edge;
  logic pls_edge;
  logic pls_ready;
  logic tz_en;
  logic tz_hit;
  logic [31:0] tz_pos;
  logic [31:0] tz_base;
  logic [31:0] sel_w;
  logic [31:0] sel_o;
  logic [31:0] wval;
  logic [2:0] zi;
  logic [1:0] oi;

  always_comb begin
    wb_req = i_wb.cyc && i_wb.stb && !st_q.ack;
    adv_edge = st_q.sy2[SY_ADV] && !st_q.prev[SY_ADV];
    clr_edge = st_q.sy2[SY_CLR] && !st_q.prev[SY_CLR];
    pls_edge = st_q.sy2[SY_PLS] && !st_q.prev[SY_PLS];
    pls_ready = i_mot.excited && !i_mot.stop_active && !st_q.sy2[SY_INH];
    sel_o = st_q.oo[i_mot.op_sel];
    sel_w = st_q.ow[i_mot.op_sel];
    tz_en = (sel_w != W_DISABLE);
    tz_pos = st_q.ctrl[C_TZSRC] ? i_mot.cmd_pos : i_mot.fb_pos;
    tz_base = i_mot.continuous ? i_mot.start_pos : i_mot.target;
    tz_hit = tz_en && near(tz_pos, tz_base, sel_o, sel_w);
    zi = 3'((i_wb.adr - A_ZONE) >> 3);
    oi = i_wb.adr[4:3];
    wval = RST_ZERO;
  end

  always_comb begin
    st_d = st_q;
    st_d.ack = wb_req;
    st_d.rdat = RST_ZERO;
    if (wb_req && !i_wb.we) begin
      if (i_wb.adr == A_CTRL) begin
        st_d.rdat = {28'h000_0000, st_q.ctrl};
      end else if (i_wb.adr == A_STAT) begin
        st_d.rdat = {11'h000, st_q.flags};
      end else if (i_wb.adr == A_LOST) begin
        st_d.rdat = st_q.lost;
      end else if (i_wb.adr == A_SLF) begin
        st_d.rdat = st_q.slf;
      end else if (i_wb.adr == A_SLR) begin
        st_d.rdat = st_q.slr;
      end else if (i_wb.adr == A_ZCFG) begin
        st_d.rdat = {16'h0000, st_q.zcfg};
      end else if (i_wb.adr >= A_ZONE && i_wb.adr < A_OP && i_wb.adr[1:0] == 2'h0) begin
        st_d.rdat = i_wb.adr[2] ? st_q.zl[zi] : st_q.zu[zi];
      end else if (i_wb.adr >= A_OP && i_wb.adr < A_END && i_wb.adr[1:0] == 2'h0) begin
        st_d.rdat = i_wb.adr[2] ? st_q.ow[oi] : st_q.oo[oi];
      end
    end
    if (wb_req && i_wb.we) begin
      if (i_wb.adr == A_CTRL) begin
        st_d.ctrl = 4'(bmask({28'h000_0000, st_q.ctrl}, i_wb.dat, i_wb.sel));
      end else if (i_wb.adr == A_SLF) begin
        st_d.slf = bmask(st_q.slf, i_wb.dat, i_wb.sel);
      end else if (i_wb.adr == A_SLR) begin
        st_d.slr = bmask(st_q.slr, i_wb.dat, i_wb.sel);
      end else if (i_wb.adr == A_ZCFG) begin
        st_d.zcfg = 16'(bmask({16'h0000, st_q.zcfg}, i_wb.dat, i_wb.sel));
      end else if (i_wb.adr >= A_ZONE && i_wb.adr < A_OP && i_wb.adr[1:0] == 2'h0) begin
        if (i_wb.adr[2]) begin
          st_d.zl[zi] = bmask(st_q.zl[zi], i_wb.dat, i_wb.sel);
        end else begin
          st_d.zu[zi] = bmask(st_q.zu[zi], i_wb.dat, i_wb.sel);
        end
      end else if (i_wb.adr >= A_OP && i_wb.adr < A_END && i_wb.adr[1:0] == 2'h0) begin
        if (i_wb.adr[2]) begin
          // out of range widths are refused, the old value stays
          if (bmask(st_q.ow[oi], i_wb.dat, i_wb.sel) == W_DISABLE ||
              bmask(st_q.ow[oi], i_wb.dat, i_wb.sel) <= W_MAX) begin
            st_d.ow[oi] = bmask(st_q.ow[oi], i_wb.dat, i_wb.sel);
          end
        end else begin
          st_d.oo[oi] = bmask(st_q.oo[oi], i_wb.dat, i_wb.sel);
        end
      end else if (i_wb.adr == A_LOST) begin
        st_d.lost = RST_ZERO;
      end
    end
    // host pins: two flops, then edge reference
    st_d.sy1 = {i_pulse_dir, i_pulse, i_pulse_inhibit, i_latch_clear, i_advance};
    st_d.sy2 = st_q.sy1;
    st_d.prev = st_q.sy2;
    st_d.flags.zone_flag = zone_hit;
    st_d.flags.target_zone_flag = tz_hit && (!st_q.ctrl[C_TZSRC+1] || i_mot.busy);
    st_d.flags.fwd_soft_limit_flag = st_q.ctrl[C_SLEN] &&
                                     ($signed(i_mot.cmd_pos) > $signed(st_q.slf));
    st_d.flags.rev_soft_limit_flag = st_q.ctrl[C_SLEN] &&
                                     ($signed(i_mot.cmd_pos) < $signed(st_q.slr));
    if (i_mot.wrap_pass) begin
      st_d.flags.wrap_overflow_toggle = !st_q.flags.wrap_overflow_toggle;
    end
    st_d.flags.pulse_report_ready = i_mot.report_prep && !i_mot.report_busy;
    st_d.flags.electrical_home_valid = i_mot.elec_home_en;
    st_d.flags.pulse_input_ready = pls_ready;
    if (i_mot.coord_set) begin
      st_d.flags.coordinate_valid = 1'b1;
      st_d.flags.home_reset_needed = 1'b0;
    end else if (i_mot.res_change && i_mot.preset_nonzero && st_q.flags.coordinate_valid) begin
      st_d.flags.home_reset_needed = 1'b1;
    end
    // clear first, then sets so that a set in the clear cycle wins
    if (clr_edge) begin
      st_d.flags.low_event_latched = 1'b0;
      st_d.flags.high_event_latched = 1'b0;
      st_d.flags.advance_latched = 1'b0;
      st_d.flags.lost_pulse_flag = 1'b0;
    end
    if (i_mot.evt_low) begin
      st_d.flags.low_event_latched = 1'b1;
    end
    if (i_mot.evt_high) begin
      st_d.flags.high_event_latched = 1'b1;
    end
    if (adv_edge) begin
      st_d.flags.advance_latched = 1'b1;
    end
    if (pls_edge && !pls_ready) begin
      st_d.flags.lost_pulse_flag = 1'b1;
      if (st_q.ctrl[C_LSGN] && st_q.sy2[SY_DIR]) begin
        st_d.lost = st_q.lost - ONE;
      end else begin
        st_d.lost = st_q.lost + ONE;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_q <= '0;
      st_q.ow <= {N_OP{W_DISABLE}};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_wb.ack = st_q.ack;
  assign o_wb.dat = st_q.rdat;
  assign o_flags = st_q.flags;
  assign o_lost_count = st_q.lost;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  a_wb_ack_next: assert property (wb_req |=> o_wb.ack ##1 !o_wb.ack)
    else $error("ack not a single pulse after request");
  a_tz_disabled: assert property (!tz_en |=> !o_flags.target_zone_flag)
    else $error("target zone flag while disabled");
  a_tz_done_off: assert property (
    st_q.ctrl[C_TZSRC+1] && !i_mot.busy |=> !o_flags.target_zone_flag)
    else $error("target zone flag after completion");
  a_zone_equal: assert property (
    !st_q.zcfg[2] && st_q.zu[2] == st_q.zl[2] && g_zone[2].p != st_q.zu[2]
    |=> !o_flags.zone_flag[2])
    else $error("zone flag with unequal position");
  a_fwd_limit: assert property (
    st_q.ctrl[C_SLEN] && $signed(i_mot.cmd_pos) > $signed(st_q.slf)
    |=> o_flags.fwd_soft_limit_flag)
    else $error("forward soft limit missed");
  a_rev_limit: assert property (
    st_q.ctrl[C_SLEN] && $signed(i_mot.cmd_pos) < $signed(st_q.slr)
    |=> o_flags.rev_soft_limit_flag)
    else $error("reverse soft limit missed");
  a_wrap_flip: assert property (
    i_mot.wrap_pass |=> o_flags.wrap_overflow_toggle != $past(o_flags.wrap_overflow_toggle))
    else $error("wrap output did not toggle");
  a_report_ready: assert property (
    i_mot.report_prep && !i_mot.report_busy |=> o_flags.pulse_report_ready)
    else $error("report ready missed");
  a_report_busy: assert property (i_mot.report_busy |=> !o_flags.pulse_report_ready)
    else $error("report ready while reporting");
  a_elec_home: assert property (i_mot.elec_home_en |=> o_flags.electrical_home_valid)
    else $error("electrical home valid missed");
  a_coord_valid: assert property (i_mot.coord_set |=> o_flags.coordinate_valid)
    else $error("coordinate valid missed");
  a_low_event: assert property (i_mot.evt_low |=> o_flags.low_event_latched)
    else $error("low event not latched");
  a_high_event: assert property (i_mot.evt_high |=> o_flags.high_event_latched)
    else $error("high event not latched");
  a_adv_latch: assert property ($rose(st_q.sy2[SY_ADV]) |=> o_flags.advance_latched)
    else $error("advance edge not latched");
  a_clr_events: assert property (
    clr_edge && !i_mot.evt_low |=> !o_flags.low_event_latched)
    else $error("low event latch survived clear");
  a_clr_lost: assert property (
    clr_edge && !(pls_edge && !pls_ready) |=> !o_flags.lost_pulse_flag)
    else $error("lost flag survived clear");
  a_lost_set: assert property (
    pls_edge && !pls_ready
    |=> o_flags.lost_pulse_flag ##1 (o_flags.lost_pulse_flag || $past(clr_edge)))
    else $error("lost pulse not latched");
  a_input_ready: assert property (!pls_ready |=> !o_flags.pulse_input_ready)
    else $error("input ready while disabled");
  a_lost_signed: assert property (
    pls_edge && !pls_ready && st_q.ctrl[C_LSGN] && st_q.sy2[SY_DIR]
    |=> o_lost_count == $past(o_lost_count) - ONE)
    else $error("signed lost count not decremented");
  a_home_set: assert property (
    i_mot.res_change && i_mot.preset_nonzero && o_flags.coordinate_valid && !i_mot.coord_set
    |=> o_flags.home_reset_needed)
    else $error("home reset flag not set");
  a_home_reset: assert property (
    i_mot.res_change && !i_mot.preset_nonzero && !i_mot.coord_set
    |=> o_flags.home_reset_needed == $past(o_flags.home_reset_needed))
    else $error("home reset flag moved on zero preset");

  c_tz_hit: cover property (tz_en ##1 o_flags.target_zone_flag);
  c_zone_wrap: cover property (o_flags.zone_flag[1] && st_q.zu[1] < st_q.zl[1]);
  c_lost_clr: cover property (o_flags.lost_pulse_flag ##[1:20] clr_edge);
  c_wb_write: cover property (wb_req && i_wb.we ##1 o_wb.ack);
  c_signed_loss: cover property (pls_edge && !pls_ready && st_q.ctrl[C_LSGN]);

endmodule : pzl_status

//--- hdl/pzl_pkg.sv
// Purpose: shared constants and carriers of the position zone and latch status block
// Assumes: 32-bit classic wishbone, byte addressed, word aligned
// Notes: zone registers at A_ZONE + 8*ch (+4 = lower), op entries at A_OP + 8*op (+4 = width)
package pzl_pkg;
  localparam int N_ZONE = 8;
  localparam int N_OP = 4;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_LOST = 8'h08;
  localparam logic [7:0] A_SLF = 8'h0C;
  localparam logic [7:0] A_SLR = 8'h10;
  localparam logic [7:0] A_ZCFG = 8'h14;
  localparam logic [7:0] A_ZONE = 8'h20;
  localparam logic [7:0] A_OP = 8'h60;
  localparam logic [7:0] A_END = 8'h80;
  localparam int C_TZSRC = 0;
  localparam int C_LSGN = 2;
  localparam int C_SLEN = 3;
  localparam int Z_SRC = 8;
  localparam logic [31:0] W_DISABLE = 32'hFFFF_FFFF;
  localparam logic [31:0] W_MAX = 32'h003F_FFFF;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam int SY_ADV = 0;
  localparam int SY_CLR = 1;
  localparam int SY_INH = 2;
  localparam int SY_PLS = 3;
  localparam int SY_DIR = 4;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } pzl_wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } pzl_wb_rsp_s;

  typedef struct packed {
    logic [31:0] fb_pos;
    logic [31:0] cmd_pos;
    logic [31:0] target;
    logic [31:0] start_pos;
    logic [1:0] op_sel;
    logic continuous;
    logic busy;
    logic excited;
    logic stop_active;
    logic wrap_pass;
    logic coord_set;
    logic elec_home_en;
    logic report_prep;
    logic report_busy;
    logic res_change;
    logic preset_nonzero;
    logic evt_low;
    logic evt_high;
  } pzl_mot_s;

  typedef struct packed {
    logic pulse_input_ready;
    logic lost_pulse_flag;
    logic advance_latched;
    logic high_event_latched;
    logic low_event_latched;
    logic home_reset_needed;
    logic coordinate_valid;
    logic electrical_home_valid;
    logic pulse_report_ready;
    logic wrap_overflow_toggle;
    logic rev_soft_limit_flag;
    logic fwd_soft_limit_flag;
    logic target_zone_flag;
    logic [7:0] zone_flag;
  } pzl_flags_s;
endpackage : pzl_pkg

//--- sim/pzl_host_model.sv
// Purpose: host controller model driving the advance, clear and pulse pins
// Assumes: pins change just after a rising edge of i_clk
// Notes: hold sets how long a strobe stands, prompt (3) or slow (6)
`timescale 1ns/1ps
module pzl_host_model (
  input wire logic i_clk,
  output logic o_advance,
  output logic o_latch_clear,
  output logic o_pulse_inhibit,
  output logic o_pulse,
  output logic o_pulse_dir
);
  initial begin
    o_advance = 1'b0;
    o_latch_clear = 1'b0;
    o_pulse_inhibit = 1'b0;
    o_pulse = 1'b0;
    o_pulse_dir = 1'b0;
  end

  // one off-to-on edge per strobe, held past the two sync flops
  task automatic strobe(input int k, input int hold);
    @(posedge i_clk);
    if (k == 0) o_advance <= 1'b1;
    else if (k == 1) o_latch_clear <= 1'b1;
    else o_pulse <= 1'b1;
    repeat (hold) @(posedge i_clk);
    o_advance <= 1'b0;
    o_latch_clear <= 1'b0;
    o_pulse <= 1'b0;
    repeat (hold) @(posedge i_clk);
  endtask : strobe

  task automatic set_pins(input logic inh, input logic dir);
    @(posedge i_clk);
    o_pulse_inhibit <= inh;
    o_pulse_dir <= dir;
  endtask : set_pins
endmodule : pzl_host_model

//--- sim/pzl_status_tb_top.sv
// Purpose: self-checking bench of the zone and latch status block
// Assumes: wishbone ack one cycle after take; flags settle within five cycles
// Notes: positions driven directly on the motion core input
`timescale 1ns/1ps
module pzl_status_tb_top import pzl_pkg::*; ();
  logic i_clk;
  logic i_sys_rst;
  pzl_wb_req_s wb_q;
  pzl_wb_rsp_s o_wb;
  pzl_mot_s mot;
  pzl_mot_s mot_in;
  logic [4:0] pv;
  pzl_flags_s o_flags;
  logic [31:0] o_lost_count;
  logic adv, clr, inh, pls, dir;
  logic [31:0] rd;
  int bad_count;
  int compares;
  localparam logic [7:0] RA [6] = '{A_OP + 8'h04, A_OP, A_ZONE, A_ZONE + 8'h04, A_ZCFG, A_END};
  localparam logic [7:0] CA [13] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C,
    A_ZCFG, A_OP, A_OP + 8'h04, A_SLF, A_SLR};
  localparam logic [31:0] CD [13] = '{32'h0000_0064, 32'h0000_0032, 32'h0000_000A,
    32'h0000_0032, 32'h0000_0014, 32'h0000_0014, 32'h0000_0000, 32'h0000_0005,
    32'h0000_0808, 32'hFFFF_EC78, 32'h0000_000A, 32'h0000_03E8, 32'hFFFF_FC18};
  localparam logic [31:0] ZP [6] = '{32'h0000_004B, 32'h0000_0065, 32'h0000_001E,
    32'h0000_0014, 32'h0000_0005, 32'h0000_0005};
  localparam logic [31:0] ZC [6] = '{32'h0000_03EB, 32'h0000_03EB, 32'h0000_03EB,
    32'h0000_03EB, 32'h0000_03EB, 32'h0000_03EE};
  localparam logic [7:0] ZE [6] = '{8'h0B, 8'h0A, 8'h08, 8'h0C, 8'h0A, 8'h02};

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  always_comb begin
    mot_in = mot;
    mot_in.wrap_pass = pv[0];
    mot_in.coord_set = pv[1];
    mot_in.res_change = pv[2];
    mot_in.evt_low = pv[3];
    mot_in.evt_high = pv[4];
  end

  pzl_host_model u_host (.i_clk(i_clk), .o_advance(adv), .o_latch_clear(clr),
    .o_pulse_inhibit(inh), .o_pulse(pls), .o_pulse_dir(dir));

  pzl_status u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb(wb_q), .i_mot(mot_in),
    .i_advance(adv), .i_latch_clear(clr), .i_pulse_inhibit(inh), .i_pulse(pls),
    .i_pulse_dir(dir), .o_wb(o_wb), .o_flags(o_flags), .o_lost_count(o_lost_count));

  task automatic print_verdict();
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask : chkb

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    wb_q <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb.ack !== 1'b1 && n < 20);
    rd = o_wb.dat;
    wb_q <= '0;
    if (o_wb.ack !== 1'b1) begin
      bad_count++;
      print_verdict();
    end
  endtask : wb

  task automatic st();
    repeat (5) @(posedge i_clk);
  endtask : st

  task automatic setp(input logic [31:0] fb, input logic [31:0] cmd);
    @(posedge i_clk);
    mot.fb_pos <= fb;
    mot.cmd_pos <= cmd;
    st();
  endtask : setp

  task automatic pl(input int k);
    @(posedge i_clk);
    pv[k] <= 1'b1;
    @(posedge i_clk);
    pv <= '0;
    st();
  endtask : pl

  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    print_verdict();
  end

  initial begin
    wb_q = '0;
    mot = '0;
    pv = '0;
    i_sys_rst = 1'b1;
    bad_count = 0;
    compares = 0;
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, RA[i], 32'h0000_0000);
      chk("reset read", (i == 0) ? W_DISABLE : RST_ZERO, rd);
    end
    chk("zone at zero", 32'h0000_00FF, {24'h0, o_flags.zone_flag});
    chkb("target off", 1'b0, o_flags.target_zone_flag);
    for (int i = 0; i < 13; i++) wb(1'b1, CA[i], CD[i]);
    wb(1'b1, A_OP + 8'h04, 32'h0040_0000);
    wb(1'b0, A_OP + 8'h04, 32'h0000_0000);
    chk("width kept", 32'h0000_000A, rd);
    @(posedge i_clk);
    mot.target <= 32'h0000_03E8;
    for (int i = 0; i < 6; i++) begin
      setp(ZP[i], ZC[i]);
      chk("zone", {24'h0, ZE[i]}, {24'h0, o_flags.zone_flag});
    end
    @(posedge i_clk);
    mot.target <= 32'h0000_2710;
    setp(32'h0000_1392, 32'h0000_0000);
    chkb("target in", 1'b1, o_flags.target_zone_flag);
    setp(32'h0000_1393, 32'h0000_0000);
    chkb("target out", 1'b0, o_flags.target_zone_flag);
    @(posedge i_clk);
    mot.continuous <= 1'b1;
    mot.start_pos <= 32'h0000_07D0;
    setp(32'hFFFF_F452, 32'h0000_0000);
    chkb("target start", 1'b1, o_flags.target_zone_flag);
    wb(1'b1, A_CTRL, 32'h0000_0002);
    st();
    chkb("target idle", 1'b0, o_flags.target_zone_flag);
    @(posedge i_clk);
    mot.busy <= 1'b1;
    st();
    chkb("target busy", 1'b1, o_flags.target_zone_flag);
    wb(1'b1, A_CTRL, 32'h0000_0003);
    setp(32'h0000_0000, 32'hFFFF_F452);
    chkb("target cmd", 1'b1, o_flags.target_zone_flag);
    @(posedge i_clk);
    mot.op_sel <= 2'h1;
    st();
    chkb("target op one", 1'b0, o_flags.target_zone_flag);
    wb(1'b1, A_CTRL, 32'h0000_0008);
    setp(32'h0000_0000, 32'h0000_03EE);
    chkb("fwd limit", 1'b1, o_flags.fwd_soft_limit_flag);
    setp(32'h0000_0000, 32'hFFFF_FC17);
    chkb("rev limit", 1'b1, o_flags.rev_soft_limit_flag);
    chkb("fwd clear", 1'b0, o_flags.fwd_soft_limit_flag);
    pl(0);
    chkb("wrap one", 1'b1, o_flags.wrap_overflow_toggle);
    pl(0);
    chkb("wrap two", 1'b0, o_flags.wrap_overflow_toggle);
    pl(1);
    chkb("coord valid", 1'b1, o_flags.coordinate_valid);
    pl(2);
    chkb("home reset zero", 1'b0, o_flags.home_reset_needed);
    @(posedge i_clk);
    mot.preset_nonzero <= 1'b1;
    pl(2);
    chkb("home reset", 1'b1, o_flags.home_reset_needed);
    pl(1);
    chkb("home reset off", 1'b0, o_flags.home_reset_needed);
    @(posedge i_clk);
    mot.elec_home_en <= 1'b1;
    mot.report_prep <= 1'b1;
    st();
    chkb("elec home", 1'b1, o_flags.electrical_home_valid);
    chkb("report ready", 1'b1, o_flags.pulse_report_ready);
    @(posedge i_clk);
    mot.report_busy <= 1'b1;
    st();
    chkb("report busy", 1'b0, o_flags.pulse_report_ready);
    pl(3);
    pl(4);
    chkb("low event", 1'b1, o_flags.low_event_latched);
    chkb("high event", 1'b1, o_flags.high_event_latched);
    u_host.strobe(0, 3);
    chkb("advance", 1'b1, o_flags.advance_latched);
    @(posedge i_clk);
    mot.excited <= 1'b1;
    u_host.strobe(2, 3);
    chkb("input ready", 1'b1, o_flags.pulse_input_ready);
    chkb("no loss", 1'b0, o_flags.lost_pulse_flag);
    u_host.set_pins(1'b1, 1'b0);
    u_host.strobe(2, 6);
    chkb("loss", 1'b1, o_flags.lost_pulse_flag);
    chk("loss count", 32'h0000_0001, o_lost_count);
    wb(1'b0, A_LOST, 32'h0000_0000);
    chk("lost read", 32'h0000_0001, rd);
    wb(1'b1, A_LOST, 32'h0000_0000);
    chk("lost cleared", 32'h0000_0000, o_lost_count);
    wb(1'b1, A_CTRL, 32'h0000_0004);
    u_host.set_pins(1'b1, 1'b1);
    u_host.strobe(2, 3);
    chk("signed count", 32'hFFFF_FFFF, o_lost_count);
    u_host.strobe(1, 3);
    chk("latches clear", 32'h0000_0000, {28'h0, o_flags.low_event_latched,
      o_flags.high_event_latched, o_flags.advance_latched, o_flags.lost_pulse_flag});
    wb(1'b0, A_STAT, 32'h0000_0000);
    chk("status read", 32'h0000_60F2, rd);
    print_verdict();
  end
endmodule : pzl_status_tb_top
